/* cwg_pkg.sv */
/*
  cwg_pkg: shared constants for the configuration write guard, its
  register offsets, command register map of the host end and timing counts.
  assumes a 100 MHz clock on both ends.
*/
package cwg_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // configuration space of the device end (low byte of the address)
  localparam logic [7:0] REG_THRESH = 8'h08;
  localparam logic [7:0] REG_OUTCFG_BASE = 8'h10;
  localparam logic [7:0] REG_WDCFG = 8'h20;
  localparam logic [7:0] REG_GUARD = 8'h43;
  localparam logic [7:0] REG_LOCK = 8'h45;
  localparam logic [7:0] REG_REBOOT = 8'h4f;
  localparam logic [15:0] EE_BASE = 16'h8000;
  localparam int EE_SEL_BIT = 15;
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] GUARD_RESET = 8'h00;
  localparam logic [7:0] FIVE_OUT_UNUSED = 8'h83;
  // output config byte: [3:0] input terms, [4] watchdog 1, [5] watchdog 2
  localparam int OC_WD1_BIT = 4;
  localparam int OC_WD2_BIT = 5;
  localparam int SINGLE_TERM_OUT = 6;
  // watchdog config byte: [1:0] sel1, [2] en1, [4:3] sel2, [5] en2
  localparam int WD_EN1_BIT = 2;
  localparam int WD_SEL2_LSB = 3;
  localparam int WD_EN2_BIT = 5;
  // timing
  localparam int CFG_LATENCY_NS = 5000;
  localparam int CFG_LATENCY_CYC = CFG_LATENCY_NS / CLK_PERIOD_NS - 1;
  localparam int THRESH_LATENCY_US = 150;
  localparam int THRESH_LATENCY_CYC = THRESH_LATENCY_US * 1000 / CLK_PERIOD_NS;
  localparam int WD_TIMEOUT_CYC = 1000;
  // host command registers over AXI4-Lite
  localparam logic [7:0] HR_ADDR = 8'h00;
  localparam logic [7:0] HR_WDATA = 8'h04;
  localparam logic [7:0] HR_CTRL = 8'h08;
  localparam logic [7:0] HR_STATUS = 8'h0c;
  localparam logic [7:0] HR_GPI = 8'h10;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WE_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_NACK_BIT = 2;
  localparam int ST_RDATA_LSB = 8;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : cwg_pkg

/* cwg_link_if.sv */
/*
  cwg_link_if: register access link and input drive between host and device.
  assumes one clock shared by both ends; the bench joins the modports.
*/
interface cwg_link_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic nack;
  logic [7:0] rdata;
  logic [3:0] gpi;

  modport device (input req, input we, input addr, input wdata, input gpi,
                  output ack, output nack, output rdata);
  modport host (output req, output we, output addr, output wdata, output gpi,
                input ack, input nack, input rdata);
endinterface : cwg_link_if

/* cwg_watchdog.sv */
/*
  cwg_watchdog: one watchdog timer kicked by any edge of a selected input.
  assumes the kick level is already synchronous to aclk.
*/
module cwg_watchdog #(
  parameter int TIMEOUT_CYC = 1000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic kick,
  output logic expired
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  if (TIMEOUT_CYC < 1) begin : g_bad_timeout
    $error("cwg_watchdog: timeout too small");
  end

  logic kick_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) kick_q <= 1'b0;
    else kick_q <= kick;
  end

  // expiry stays until the input toggles again or the timer is disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable || kick != kick_q) begin
      cnt_q <= '0;
      expired <= 1'b0;
    end else if (cnt_q == CW'(TIMEOUT_CYC)) begin
      expired <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : cwg_watchdog

/* cwg_device.sv */
/*
  cwg_device: device end of the configuration write guard. holds volatile
  configuration and its nonvolatile shadow, drives the programmable outputs
  and guards configuration writes by output state.
  assumes the host holds req until ack or nack and inputs are synchronous.
*/
// How it works
// - 8-bit guard mask with nonvolatile shadow copy
// - cleared mask bit ignores its output
// - five-output host keeps bits 0,1,7 zero
// - bit 6 guards seventh or fifth output
// - input kicks watchdog; timeout asserts dependents
// - bit-6 output has one product term
// - output held while its input is active
// - host drives inputs as interrupt sources
// - general writes apply within 5 us
// - threshold writes apply after 150 us
// - nonvolatile edits apply only at reboot
// - boot copy, link refused until done
// - lock bit 0 locks configuration
module cwg_device
  import cwg_pkg::*;
#(
  parameter int NUM_OUT = 8,
  parameter int THRESH_CYC = THRESH_LATENCY_CYC,
  parameter int WD_CYC = WD_TIMEOUT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  cwg_link_if.device link,
  output logic [7:0] prog_out_q,
  output logic [7:0] threshold_q,
  output logic booting_q
);
  localparam int DEPTH = 128;
  localparam int TW = $clog2(THRESH_CYC + 1);
  localparam int GW = $clog2(CFG_LATENCY_CYC + 1);
  if (NUM_OUT != 8 && NUM_OUT != 5) begin : g_bad_num_out
    $error("cwg_device: NUM_OUT 8 or 5");
  end
  if (THRESH_CYC < 1) begin : g_bad_thresh
    $error("cwg_device: THRESH_CYC too small");
  end

  // guard mask lives in both arrays
  logic [7:0] cfg_q [DEPTH];
  logic [7:0] ee_q [DEPTH];
  logic [6:0] boot_idx_q;
  logic ack_q, nack_q;
  logic [7:0] rdata_q;
  logic pend_q;
  logic [6:0] pend_addr_q;
  logic [7:0] pend_data_q;
  logic [GW-1:0] pend_cnt_q;
  logic tpend_q;
  logic [7:0] tpend_data_q;
  logic [TW-1:0] tcnt_q;
  logic [1:0] wd_exp;
  logic [7:0] out_d;
  logic [7:0] valid_outs;

  assign link.ack = ack_q;
  assign link.nack = nack_q;
  assign link.rdata = rdata_q;

  wire take = link.req && !ack_q && !nack_q;
  wire [6:0] idx = link.addr[6:0];
  wire to_ee = link.addr[EE_SEL_BIT];
  wire [7:0] reg_lo = {1'b0, idx};
  // positions 0,1,7 carry no output on the five-output part
  assign valid_outs = (NUM_OUT == 8) ? 8'hff : ~FIVE_OUT_UNUSED;
  // only set mask bits with an asserted output block writes
  wire guarded = |(cfg_q[REG_GUARD[6:0]] & prog_out_q & valid_outs);
  // lock blocks every configuration write but the lock itself
  wire locked = cfg_q[REG_LOCK[6:0]][LOCK_BIT] && reg_lo != REG_LOCK;
  wire wr_ok = take && link.we && !booting_q && !guarded && !locked;
  wire reboot = wr_ok && !to_ee && reg_lo == REG_REBOOT;
  wire wr_thr = wr_ok && !to_ee && reg_lo == REG_THRESH;
  wire wr_cfg = wr_ok && !to_ee && !reboot && !wr_thr;
  wire pend_due = pend_q && (pend_cnt_q == '0 || wr_cfg);

  // refuse the link while the boot copy runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= take && !booting_q;
      nack_q <= take && booting_q;
      // reads are served even when writes are guarded
      if (take && !booting_q && !link.we) begin
        if (to_ee) rdata_q <= ee_q[idx];
        else if (reg_lo == REG_THRESH) rdata_q <= threshold_q;
        else rdata_q <= cfg_q[idx];
      end
    end
  end

  // boot copy after reset, and after a reboot command
  always_ff @(posedge aclk) begin
    if (!aresetn || reboot) begin
      booting_q <= 1'b1;
      boot_idx_q <= '0;
    end else if (booting_q) begin
      boot_idx_q <= boot_idx_q + 1'b1;
      if (boot_idx_q == 7'(DEPTH - 1)) booting_q <= 1'b0;
    end
  end

  // nonvolatile writes never touch the volatile copy directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) ee_q[i] <= 8'h00;
    end else if (wr_ok && to_ee) begin
      // unused mask positions kept zero on the five-output part
      ee_q[idx] <= (reg_lo == REG_GUARD) ? (link.wdata & valid_outs) : link.wdata;
    end
  end

  // pending general write, applied within the short latency
  always_ff @(posedge aclk) begin
    if (!aresetn || booting_q) begin
      pend_q <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= 8'h00;
      pend_cnt_q <= '0;
    end else if (wr_cfg) begin
      pend_q <= 1'b1;
      pend_addr_q <= idx;
      pend_data_q <= link.wdata;
      pend_cnt_q <= GW'(CFG_LATENCY_CYC - 1);
    end else if (pend_due) begin
      pend_q <= 1'b0;
    end else if (pend_q) begin
      pend_cnt_q <= pend_cnt_q - 1'b1;
    end
  end

  // a second write flushes the first so none is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) cfg_q[i] <= 8'h00;
      cfg_q[REG_GUARD[6:0]] <= GUARD_RESET;
    end else if (booting_q) begin
      cfg_q[boot_idx_q] <= ee_q[boot_idx_q];
    end else if (pend_due) begin
      cfg_q[pend_addr_q] <= (pend_addr_q == REG_GUARD[6:0]) ?
                            (pend_data_q & valid_outs) : pend_data_q;
    end
  end

  // threshold change waits the long latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tpend_q <= 1'b0;
      tpend_data_q <= 8'h00;
      tcnt_q <= '0;
      threshold_q <= 8'h00;
    end else if (booting_q) begin
      tpend_q <= 1'b0;
      threshold_q <= cfg_q[REG_THRESH[6:0]];
    end else if (wr_thr) begin
      tpend_q <= 1'b1;
      tpend_data_q <= link.wdata;
      tcnt_q <= TW'(THRESH_CYC - 1);
    end else if (tpend_q) begin
      if (tcnt_q == '0) begin
        tpend_q <= 1'b0;
        threshold_q <= tpend_data_q;
      end else begin
        tcnt_q <= tcnt_q - 1'b1;
      end
    end
  end

  // two watchdogs, each kicked by a selected input
  wire [7:0] wdc = cfg_q[REG_WDCFG[6:0]];
  cwg_watchdog #(.TIMEOUT_CYC(WD_CYC)) u_wd1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(wdc[WD_EN1_BIT] && !booting_q),
    .kick(link.gpi[wdc[1:0]]),
    .expired(wd_exp[0])
  );
  cwg_watchdog #(.TIMEOUT_CYC(WD_CYC)) u_wd2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(wdc[WD_EN2_BIT] && !booting_q),
    .kick(link.gpi[wdc[WD_SEL2_LSB+1:WD_SEL2_LSB]]),
    .expired(wd_exp[1])
  );

  for (genvar n = 0; n < 8; n++) begin : g_out
    wire [7:0] oc = cfg_q[REG_OUTCFG_BASE[6:0] + 7'(n)];
    wire [5:0] terms = oc[5:0];
    wire [5:0] conds = {wd_exp[1], wd_exp[0], link.gpi};
    if (n == SINGLE_TERM_OUT) begin : g_single
      // one product: all selected conditions together
      assign out_d[n] = valid_outs[n] && (terms != '0) && ((conds & terms) == terms);
    end else begin : g_sum
      // any selected input held active keeps it asserted
      assign out_d[n] = valid_outs[n] && |(conds & terms);
    end
  end

  // outputs sit deasserted until the boot copy is done
  always_ff @(posedge aclk) begin
    if (!aresetn || booting_q) prog_out_q <= 8'h00;
    else prog_out_q <= out_d;
  end
endmodule : cwg_device

/* cwg_host.sv */
/*
  cwg_host: host end. software writes command registers over AXI4-Lite;
  the host runs one link access per start and drives the general inputs.
  assumes one AXI4-Lite master issuing one write and one read at a time.
*/
module cwg_host
  import cwg_pkg::*;
#(
  parameter int NUM_OUT = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  cwg_link_if.host link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (NUM_OUT != 8 && NUM_OUT != 5) begin : g_bad_num_out
    $error("cwg_host: NUM_OUT 8 or 5");
  end

  typedef enum logic [0:0] {CWG_IDLE = 1'b0, CWG_WAIT = 1'b1} cwg_state_t;
  cwg_state_t state_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic have_aw_q, have_w_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q, rdata_q;
  logic we_q, done_q, nack_q, req_q;
  logic [3:0] gpi_q;

  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.gpi = gpi_q;
  // guard mask positions without an output sent as zero
  assign link.wdata = (NUM_OUT == 5 && addr_q[7:0] == REG_GUARD) ?
                      (wdata_q & ~FIVE_OUT_UNUSED) : wdata_q;

  wire do_wr = have_aw_q && have_w_q && !s_axi_bvalid;
  wire [7:0] wa = aw_q & 8'hfc;
  wire start = do_wr && wa == HR_CTRL && ws_q[0] && w_q[CTRL_START_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
        have_aw_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
        have_w_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa <= HR_GPI) ? AXI_OKAY : AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // command fields; address, data and input writes land even while an access runs, the we bit only when idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      gpi_q <= 4'h0;
    end else if (do_wr) begin
      if (wa == HR_ADDR && ws_q[0]) addr_q[7:0] <= w_q[7:0];
      if (wa == HR_ADDR && ws_q[1]) addr_q[15:8] <= w_q[15:8];
      if (wa == HR_WDATA && ws_q[0]) wdata_q <= w_q[7:0];
      if (wa == HR_CTRL && ws_q[0] && state_q == CWG_IDLE) we_q <= w_q[CTRL_WE_BIT];
      if (wa == HR_GPI && ws_q[0]) gpi_q <= w_q[3:0];
    end
  end

  // one link access per start: req held until ack or nack, read data kept on ack
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= CWG_IDLE;
      req_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      case (state_q)
        CWG_IDLE: begin
          if (start) begin
            req_q <= 1'b1;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            state_q <= CWG_WAIT;
          end
        end
        CWG_WAIT: begin
          if (link.ack || link.nack) begin
            req_q <= 1'b0;
            done_q <= 1'b1;
            nack_q <= link.nack;
            if (link.ack && !we_q) rdata_q <= link.rdata;
            state_q <= CWG_IDLE;
          end
        end
        default: state_q <= CWG_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= AXI_OKAY;
      case (s_axi_araddr & 8'hfc)
        HR_ADDR: s_axi_rdata <= {16'h0, addr_q};
        HR_WDATA: s_axi_rdata <= {24'h0, wdata_q};
        HR_CTRL: s_axi_rdata <= {30'h0, we_q, 1'b0};
        HR_STATUS: s_axi_rdata <= {16'h0, rdata_q, 5'h0, nack_q, done_q, req_q};
        HR_GPI: s_axi_rdata <= {28'h0, gpi_q};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule : cwg_host

/* cwg_props.sv */
/*
  cwg_props: handshake checks on the link between host end and device end.
  assumes both ends share aclk and a synchronous active-low aresetn.
*/
module cwg_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic nack,
  input wire logic [7:0] rdata
);
  logic [7:0] boot_cnt_q;
  logic [7:0] boot_cnt_d;

  assign boot_cnt_d = (boot_cnt_q == 8'hff) ? boot_cnt_q : boot_cnt_q + 8'h01;

  // cycles since reset release, saturating; boot copy sits inside the first 128
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      boot_cnt_q <= 8'h00;
    end else begin
      boot_cnt_q <= boot_cnt_d;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_answer_next:
    assert property ((req && !ack && !nack) |=> (ack ^ nack)) else $error("no answer");
  a_boot_refused:
    assert property ((boot_cnt_q < 8'h78 && req && !ack && !nack) |=> nack)
    else $error("boot access not refused");
  a_answer_single:
    assert property ((ack || nack) |=> (!ack && !nack)) else $error("answer too long");
  a_answer_excl:
    assert property (!(ack && nack)) else $error("ack with nack");
  a_req_release:
    assert property ((ack || nack) |=> !req) else $error("req kept after answer");
  a_req_steady:
    assert property ((req && !ack && !nack) |=> req && $stable(addr) && $stable(we)
      && $stable(wdata)) else $error("request moved");
  a_rdata_cause:
    assert property (!$stable(rdata) |-> (ack && !we)) else $error("rdata moved");
  a_idle_release:
    assert property ($rose(aresetn) |-> (!ack && !nack && !req)) else $error("busy link");
endmodule : cwg_props

/* config_write_guard_tb.sv */
/*
  config_write_guard_tb: drives the host end over AXI4-Lite, the device end
  answers over the shared link; reads are checked from a queue of notes.
  assumes short threshold and watchdog counts so the run stays brief.
*/
module config_write_guard_tb
  import cwg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr, prog_out_q, threshold_q, seed, thr_exp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, booting_q;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  int fails, check_count, i;

  cwg_link_if link();
  cwg_device #(.THRESH_CYC(20), .WD_CYC(16)) i_cwg_device (.aclk(aclk), .aresetn(aresetn),
    .link(link), .prog_out_q(prog_out_q), .threshold_q(threshold_q), .booting_q(booting_q));
  cwg_host i_cwg_host (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  cwg_props i_cwg_props (.aclk(aclk), .aresetn(aresetn), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .nack(link.nack),
    .rdata(link.rdata));

  always #5 aclk = ~aclk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic stop_test;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic fail_wait;
    fails++;
    $display("wrong value at %0t: wait ran out", $time);
    stop_test();
  endtask : fail_wait

  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask : ticks

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        s_axi_bready <= 1'b0;
        rr = s_axi_bresp;
        done = 1'b1;
      end
    end
    if (!done) fail_wait();
  endtask : axi_write

  // a mask of zero marks a poll whose data is not judged
  task automatic axi_read(input logic [7:0] a, input logic [31:0] want, input logic [31:0] m);
    int n;
    logic done;
    done = 1'b0;
    exp_q.push_back({want, m});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        done = 1'b1;
      end
    end
    if (!done) fail_wait();
  endtask : axi_read

  task automatic link_op(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    axi_write(HR_ADDR, {16'h0000, a});
    axi_write(HR_WDATA, {24'h000000, d});
    axi_write(HR_CTRL, (32'h1 << CTRL_START_BIT) | (32'(w) << CTRL_WE_BIT));
    for (n = 0; n < 20; n++) begin
      axi_read(HR_STATUS, 32'h0, 32'h0);
      if (rd[ST_DONE_BIT] === 1'b1 && rd[ST_BUSY_BIT] === 1'b0) break;
    end
    if (n == 20) fail_wait();
  endtask : link_op

  task automatic dev_read(input logic [7:0] a, input logic [7:0] v);
    link_op(1'b0, {8'h00, a}, 8'h00);
    axi_read(HR_STATUS, {16'h0000, v, 8'h00},
      (32'hff << ST_RDATA_LSB) | (32'h1 << ST_NACK_BIT));
  endtask : dev_read

  // threshold must hold its old value for the long latency, then follow only when ok is set
  task automatic thr_write(input logic ok);
    seed = lfsr(seed);
    link_op(1'b1, {8'h00, REG_THRESH}, seed);
    check({24'h0, threshold_q}, {24'h0, thr_exp});
    if (ok) thr_exp = seed;
    ticks(25);
    check({24'h0, threshold_q}, {24'h0, thr_exp});
  endtask : thr_write

  // the monitor pairs every read answer with the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[31:0] != 32'h0) check(s_axi_rdata & note[31:0], note[63:32]);
    end
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    seed = 8'h28;
    thr_exp = 8'h00;
    fails = 0;
    check_count = 0;
    ticks(16);
    aresetn <= 1'b1;
    link_op(1'b1, {8'h00, REG_GUARD}, 8'hff);
    axi_read(HR_STATUS, 32'h1 << ST_NACK_BIT, 32'h1 << ST_NACK_BIT);
    for (i = 0; i < 200 && booting_q !== 1'b0; i++) ticks(1);
    if (i == 200) fail_wait();
    dev_read(REG_GUARD, GUARD_RESET);
    axi_read(8'h40, 32'h0, 32'hffffffff);
    check({30'h0, rr}, {30'h0, AXI_SLVERR});
    axi_write(8'h40, 32'h0);
    check({30'h0, rr}, {30'h0, AXI_SLVERR});
    axi_write(HR_GPI, 32'h0);
    check({30'h0, rr}, {30'h0, AXI_OKAY});
    link_op(1'b1, {8'h00, REG_OUTCFG_BASE + 8'h06}, 8'h01);
    link_op(1'b1, {8'h00, REG_OUTCFG_BASE + 8'h02}, 8'h02);
    ticks(510);
    axi_write(HR_GPI, 32'h1);
    ticks(5);
    check({24'h0, prog_out_q}, 32'h40);
    axi_write(HR_GPI, 32'h2);
    ticks(5);
    check({24'h0, prog_out_q}, 32'h04);
    link_op(1'b1, {8'h00, REG_GUARD}, 8'h40);
    ticks(510);
    thr_write(1'b1);
    axi_write(HR_GPI, 32'h1);
    ticks(5);
    thr_write(1'b0);
    dev_read(REG_GUARD, 8'h40);
    axi_write(HR_GPI, 32'h0);
    ticks(5);
    link_op(1'b1, {8'h00, REG_LOCK}, 8'h01);
    ticks(510);
    thr_write(1'b0);
    link_op(1'b1, {8'h00, REG_LOCK}, 8'h00);
    ticks(510);
    thr_write(1'b1);
    link_op(1'b1, EE_BASE | {8'h00, REG_GUARD}, 8'h3c);
    ticks(5);
    dev_read(REG_GUARD, 8'h40);
    link_op(1'b1, {8'h00, REG_REBOOT}, 8'h00);
    check({31'h0, booting_q}, 32'h1);
    ticks(140);
    dev_read(REG_GUARD, 8'h3c);
    link_op(1'b1, {8'h00, REG_WDCFG}, 8'h06);
    link_op(1'b1, {8'h00, REG_OUTCFG_BASE + 8'h03}, 8'h10);
    ticks(540);
    check({31'h0, prog_out_q[3]}, 32'h1);
    // toggling faster than the timeout keeps the dependent output released
    for (i = 0; i < 10; i++) axi_write(HR_GPI, {29'h0, i[0], 2'b00});
    check({31'h0, prog_out_q[3]}, 32'h0);
    stop_test();
  end
endmodule : config_write_guard_tb
